// ---- src/host_watchdog_pkg.sv ----
// Package for the two-stage host watchdog: register map, fields, commands, timing.
// Assumes a 40 MHz system clock and an APB register port.
package host_watchdog_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int FIRST_UNIT_MS = 100;
	localparam int SECOND_UNIT_MS = 1000;
	localparam int FIRST_TICK_CYCLES = CLK_HZ / 1000 * FIRST_UNIT_MS;
	localparam int SECOND_TICK_CYCLES = CLK_HZ / 1000 * SECOND_UNIT_MS;
	// Register byte offsets
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_HOSTPORT = 8'h10;
	// Command codes written to OFS_COMMAND
	localparam logic [7:0] CMD_CONFIGURE = 8'h01;
	localparam logic [7:0] CMD_HEARTBEAT = 8'h02;
	localparam logic [7:0] CMD_CLEAR_WARN = 8'h03;
	// Stop pattern: all-ones countdown with zero pre-timeout
	localparam logic [15:0] STOP_COUNT = 16'hffff;
	localparam logic [7:0] STOP_PRE = 8'h00;
	// Status bit positions
	localparam int ST_RUNNING = 0;
	localparam int ST_STAGE2 = 1;
	localparam int ST_WARN = 2;
	localparam int ST_FIRED = 3;
	localparam int ST_OBF = 4;
	localparam int ST_VEND1 = 5;
	localparam logic [7:0] WARN_BYTE = 8'h5a;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ---- src/two_stage_host_watchdog.sv ----
// Two-stage host watchdog with APB registers and a power-toggle output.
// Assumes a single clk_sys domain; APB master keeps the bus protocol.
// Overview of operation
// [RQ1] Final expiry toggles board power module
// [RQ2] Host re-arms watchdog itself after restart
// [RQ3] Buffer-full and vendor flags survive host reset
// [RQ4] Host reads data byte to clear stale flag
// [RQ5] Pre-timeout waits until warning dispatched
// [RQ6] Clear command drops interrupt, rewinds timer
// [RQ7] State query returns timers and state bits
// [RQ8] Configure loads reloads; ffff/00 stops watchdog
// [RQ9] Heartbeat starts or restarts countdown
// [RQ10] First stage: 16-bit count, 100 ms units
// [RQ11] Pre-timeout counted in seconds
// [RQ12] Zero pre-timeout resets directly on expiry
// [RQ13] First expiry warns host, starts second stage
// [RQ14] Counters decrement per unit tick
`timescale 1ns/1ps
module two_stage_host_watchdog
	import host_watchdog_pkg::*;
#(
	parameter int FIRST_TICK = FIRST_TICK_CYCLES,
	parameter int SECOND_TICK = SECOND_TICK_CYCLES,
	parameter int PULSE_CYCLES = 16
) (
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic warn_irq, // Watchdog warning to host, level
	output logic power_toggle // Power module toggle pulse
);
	typedef enum logic [1:0] {IDLE, STAGE1, WARN, STAGE2} wd_state_t;
	typedef struct packed {
		wd_state_t st;
		logic [15:0] rel1;
		logic [7:0] rel2;
		logic [15:0] cnt1;
		logic [7:0] cnt2;
		logic [31:0] tick;
		logic [7:0] pulse;
		logic pwr;
		logic fired;
		logic output_buffer_full_flag;
		logic vend1;
		logic irq;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} wd_regs_t;
	wd_regs_t s_reg, s_next;

	logic acc, fin, wr, rd, hit;
	logic [7:0] cmd;
	logic tick_due;
	assign acc = psel && penable && !s_reg.ready;
	// Writes and the buffer drain land on the edge that completes the transfer
	assign fin = psel && penable && s_reg.ready;
	assign wr = fin && pwrite;
	assign rd = acc && !pwrite;
	assign cmd = pwdata[7:0];
	assign hit = paddr == OFS_COMMAND || paddr == OFS_CONFIG || paddr == OFS_STATUS ||
		paddr == OFS_COUNT || paddr == OFS_HOSTPORT;
	assign tick_due = (s_reg.st == STAGE2) ? (s_reg.tick >= 32'(SECOND_TICK - 1)) :
		(s_reg.tick >= 32'(FIRST_TICK - 1));

	function automatic logic [31:0] status_word(input wd_regs_t r);
		logic [31:0] w;
		w = ZERO_WORD;
		w[ST_RUNNING] = r.st != IDLE;
		w[ST_STAGE2] = r.st == STAGE2;
		w[ST_WARN] = r.irq;
		w[ST_FIRED] = r.fired;
		w[ST_OBF] = r.output_buffer_full_flag;
		w[ST_VEND1] = r.vend1;
		return w;
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.ready = acc;
		s_next.err = acc && !hit;
		if (s_reg.pulse != 8'h00) begin
			s_next.pulse = s_reg.pulse - 8'h01;
		end
		if (s_reg.st == IDLE || s_reg.st == WARN) begin
			s_next.tick = ZERO_WORD;
		end else if (tick_due) begin
			s_next.tick = ZERO_WORD;
		end else begin
			s_next.tick = s_reg.tick + 32'h1;
		end
		case (s_reg.st)
			IDLE: begin
			end
			STAGE1: begin
				if (tick_due) begin // RQ14
					if (s_reg.cnt1 <= 16'h0001) begin
						if (s_reg.rel2 == 8'h00) begin // RQ12
							s_next.st = IDLE;
							s_next.pulse = 8'(PULSE_CYCLES); // RQ1
							s_next.fired = 1'b1;
						end else begin
							s_next.st = WARN; // RQ13
							s_next.irq = 1'b1;
							s_next.output_buffer_full_flag = 1'b1;
							s_next.vend1 = 1'b1;
						end
						s_next.cnt1 = 16'h0000;
					end else begin
						s_next.cnt1 = s_reg.cnt1 - 16'h0001; // RQ10
					end
				end
			end
			WARN: begin
				// Warning counts as dispatched once the irq level is out
				if (warn_irq) begin // RQ5
					s_next.st = STAGE2;
					s_next.cnt2 = s_reg.rel2;
				end
			end
			STAGE2: begin
				if (tick_due) begin // RQ14
					if (s_reg.cnt2 <= 8'h01) begin // RQ11
						s_next.st = IDLE;
						s_next.cnt2 = 8'h00;
						s_next.pulse = 8'(PULSE_CYCLES); // RQ1
						s_next.fired = 1'b1;
						s_next.irq = 1'b0;
					end else begin
						s_next.cnt2 = s_reg.cnt2 - 8'h01;
					end
				end
			end
			default: s_next.st = IDLE;
		endcase
		// Software actions take priority over the countdown
		if (wr && paddr == OFS_CONFIG) begin
			s_next.rel1 = pwdata[23:8]; // RQ10
			s_next.rel2 = pwdata[7:0];
			if (pwdata[23:8] == STOP_COUNT && pwdata[7:0] == STOP_PRE) begin // RQ8
				s_next.st = IDLE;
				s_next.irq = 1'b0;
			end
		end
		if (wr && paddr == OFS_COMMAND) begin
			if (cmd == CMD_HEARTBEAT || cmd == CMD_CLEAR_WARN) begin // RQ9 RQ6
				if (!(s_reg.rel1 == STOP_COUNT && s_reg.rel2 == STOP_PRE)) begin
					s_next.st = STAGE1;
					s_next.cnt1 = s_reg.rel1;
					s_next.tick = ZERO_WORD;
				end
				s_next.irq = 1'b0; // RQ6
				s_next.fired = 1'b0;
			end
		end
		// Host data byte read is the only thing that drops the flags
		if (fin && !pwrite && paddr == OFS_HOSTPORT) begin // RQ3
			s_next.output_buffer_full_flag = 1'b0;
			s_next.vend1 = 1'b0;
		end
		if (rd) begin
			case (paddr)
				OFS_CONFIG: s_next.rdata = {8'h00, s_reg.rel1, s_reg.rel2};
				OFS_STATUS: s_next.rdata = status_word(s_reg); // RQ7
				OFS_COUNT: s_next.rdata = {8'h00, s_reg.cnt1, s_reg.cnt2}; // RQ7
				OFS_HOSTPORT: s_next.rdata = {24'h000000, WARN_BYTE};
				default: s_next.rdata = ZERO_WORD;
			endcase
		end else if (acc) begin
			s_next.rdata = ZERO_WORD;
		end
		s_next.pwr = s_next.pulse != 8'h00; // RQ1
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '{st: IDLE, rel1: STOP_COUNT, rel2: STOP_PRE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.rdata;
	assign pready = s_reg.ready;
	assign pslverr = s_reg.err;
	assign warn_irq = s_reg.irq;
	assign power_toggle = s_reg.pwr;

	a_stage2_after_warn: assert property (@(posedge clk_sys) disable iff (!resetn)
		(s_reg.st == WARN) |=> (s_reg.st == STAGE2 || s_reg.st == IDLE ||
		s_reg.st == STAGE1)) else $error("warn state did not advance"); // RQ5
	a_stage2_needs_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(s_reg.st == STAGE2) |-> $past(warn_irq))
		else $error("second stage began before warning"); // RQ5
	a_fire_toggles: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(s_reg.fired) |-> power_toggle) else $error("expiry without toggle"); // RQ1
	a_flags_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(s_reg.output_buffer_full_flag) |-> $past(fin && !pwrite && paddr == OFS_HOSTPORT))
		else $error("buffer flag cleared without data read"); // RQ3
	a_heartbeat_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr && paddr == OFS_COMMAND && cmd == CMD_HEARTBEAT && s_reg.rel1 != STOP_COUNT)
		|=> (s_reg.st == STAGE1 && s_reg.cnt1 == $past(s_reg.rel1)))
		else $error("heartbeat did not load count"); // RQ9
	a_clear_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr && paddr == OFS_COMMAND && cmd == CMD_CLEAR_WARN) |=> !warn_irq)
		else $error("clear command left irq"); // RQ6
	a_stop_pattern: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr && paddr == OFS_CONFIG && pwdata[23:0] == {STOP_COUNT, STOP_PRE})
		|=> s_reg.st == IDLE) else $error("stop pattern ignored"); // RQ8
	a_direct_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
		(s_reg.st == STAGE1 && tick_due && s_reg.cnt1 <= 16'h0001 && s_reg.rel2 == 8'h00 &&
		!wr) |=> (power_toggle && !warn_irq)) else $error("direct reset missed"); // RQ12
	a_tick_only: assert property (@(posedge clk_sys) disable iff (!resetn)
		(s_reg.st == STAGE1 && !tick_due && !wr) |=> $stable(s_reg.cnt1))
		else $error("count moved without tick"); // RQ14
	a_warn_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(s_reg.st == WARN) |-> (warn_irq && s_reg.output_buffer_full_flag))
		else $error("warning not raised"); // RQ13
	a_query: assert property (@(posedge clk_sys) disable iff (!resetn)
		(rd && paddr == OFS_COUNT) |=> prdata[23:8] == $past(s_reg.cnt1))
		else $error("query value wrong"); // RQ7

	// Bus answer timing: one wait state, answer stands one cycle
	a_ready_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
		pready |=> !pready) else $error("ready stood too long");

	a_ready_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
		acc |=> pready) else $error("access not answered");

	a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!resetn)
		(acc && !hit) |=> pslverr) else $error("unmapped access not flagged");

	a_err_mapped: assert property (@(posedge clk_sys) disable iff (!resetn)
		(acc && hit) |=> !pslverr) else $error("mapped access flagged");

	a_write_reads_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		(acc && pwrite) |=> prdata == ZERO_WORD) else $error("write returned data");

	// Countdown and reset path
	a_heartbeat_clears: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ9
		(wr && paddr == OFS_COMMAND && cmd == CMD_HEARTBEAT) |=> !warn_irq)
		else $error("heartbeat left irq");

	a_stage2_reload: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ11
		$rose(s_reg.st == STAGE2) |-> s_reg.cnt2 == $past(s_reg.rel2))
		else $error("second stage not loaded");

	a_idle_tick: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ14
		(s_reg.st == IDLE) |=> s_reg.tick == ZERO_WORD) else $error("idle tick ran");

	a_stop_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
		(s_reg.st == IDLE && s_reg.rel1 == STOP_COUNT && s_reg.rel2 == STOP_PRE && !wr)
		|=> s_reg.st == IDLE) else $error("stopped watchdog started");

	a_config_load: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ10
		(wr && paddr == OFS_CONFIG) |=> {s_reg.rel1, s_reg.rel2} == $past(pwdata[23:0]))
		else $error("config not loaded");

	a_toggle_follows: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ1
		(s_reg.pulse != 8'h00) |-> power_toggle) else $error("toggle pulse missing");

	a_irq_from_stage1: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
		$rose(warn_irq) |-> $past(s_reg.st == STAGE1)) else $error("irq outside expiry");

	// Flags that outlive the host and the query path
	a_vend_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ3
		$fell(s_reg.vend1) |-> $past(fin && !pwrite && paddr == OFS_HOSTPORT))
		else $error("vendor flag cleared without data read");

	a_warn_vend: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
		$rose(warn_irq) |-> s_reg.vend1) else $error("vendor flag not set on warning");

	a_status_fired: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ7
		(rd && paddr == OFS_STATUS) |=> prdata[ST_FIRED] == $past(s_reg.fired))
		else $error("status fired bit wrong");

	a_status_running: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ7
		(rd && paddr == OFS_STATUS) |=> prdata[ST_RUNNING] == $past(s_reg.st != IDLE))
		else $error("status running bit wrong");

	a_count_low: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ7
		(rd && paddr == OFS_COUNT) |=> prdata[7:0] == $past(s_reg.cnt2))
		else $error("second count query wrong");

	c_drain: cover property (@(posedge clk_sys) $fell(s_reg.output_buffer_full_flag));
	c_unmapped: cover property (@(posedge clk_sys) pslverr);
	c_warn: cover property (@(posedge clk_sys) $rose(s_reg.st == STAGE2));
	c_fire: cover property (@(posedge clk_sys) $rose(power_toggle));
	c_rewind: cover property (@(posedge clk_sys) warn_irq ##1 !warn_irq);
endmodule

// ---- dv/host_model.sv ----
// Host-side model: the APB master through which the host reaches the watchdog.
// Assumes clk_sys from the bench and a slave that answers with pready.
`timescale 1ns/1ps
module host_model
	import host_watchdog_pkg::*;
(
	input wire logic clk_sys, // System clock
	output logic psel, // APB select
	output logic penable, // APB enable
	output logic pwrite, // APB direction
	output logic [7:0] paddr, // APB address
	output logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr // APB error
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// Answer taken at the edge where pready is sampled high, then released
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// After a watchdog reset: drain the stale byte first, then re-arm
	task automatic recover(output logic [31:0] b);
		logic [31:0] r;
		logic e;
		xfer(1'b0, OFS_HOSTPORT, ZERO_WORD, b, e);
		xfer(1'b1, OFS_COMMAND, {24'h000000, CMD_HEARTBEAT}, r, e);
	endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the two-stage host watchdog.
// Assumes shortened tick parameters so both stages expire within a few cycles.
`timescale 1ns/1ps
module testbench;
	import host_watchdog_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, warn_irq, power_toggle, err, seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int bad_count = 0;
	int n_tests = 0;
	always #12.5 clk_sys = ~clk_sys;
	host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	two_stage_host_watchdog #(.FIRST_TICK(4), .SECOND_TICK(8), .PULSE_CYCLES(16)) DUT (
		.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.warn_irq(warn_irq), .power_toggle(power_toggle));
	task automatic check(input string what, input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, x, s);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd, err);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] x);
		host.xfer(1'b0, a, ZERO_WORD, rd, err);
		check(what, rd, x);
	endtask
	// Stops early once the chosen output is high
	task automatic wait_out(input logic pick, input int n);
		seen = 1'b0;
		for (int i = 0; i < n && seen !== 1'b1; i++) begin
			@(negedge clk_sys);
			seen = pick ? power_toggle : warn_irq;
		end
	endtask
	task automatic t_regs();
		rd_chk("config", OFS_CONFIG, 32'h00ffff00);
		host.xfer(1'b0, 8'h14, ZERO_WORD, rd, err);
		check("slverr", {31'h0, err}, 32'h1);
		wr(OFS_CONFIG, 32'h00177050);
		rd_chk("config", OFS_CONFIG, 32'h00177050);
	endtask
	task automatic t_stop();
		wr(OFS_CONFIG, 32'h00001000);
		wr(OFS_COMMAND, {24'h0, CMD_HEARTBEAT});
		wr(OFS_CONFIG, {8'h00, STOP_COUNT, STOP_PRE});
		wait_out(1'b1, 300);
		check("stop", {31'h0, seen}, 32'h0);
	endtask
	task automatic t_direct();
		wr(OFS_CONFIG, 32'h00000200);
		wr(OFS_COMMAND, {24'h0, CMD_HEARTBEAT});
		wait_out(1'b1, 100);
		check("power", {31'h0, seen}, 32'h1);
		check("warn", {31'h0, warn_irq}, 32'h0);
		rd_chk("status", OFS_STATUS, 32'h8);
	endtask
	task automatic t_pre();
		wr(OFS_CONFIG, 32'h00000102);
		wr(OFS_COMMAND, {24'h0, CMD_HEARTBEAT});
		wait_out(1'b0, 100);
		check("warn", {31'h0, seen}, 32'h1);
		host.xfer(1'b0, OFS_STATUS, ZERO_WORD, rd, err);
		check("flags", {rd[ST_VEND1], rd[ST_OBF], rd[ST_WARN], rd[ST_STAGE2]}, 4'hf);
		wr(OFS_COMMAND, {24'h0, CMD_CLEAR_WARN});
		@(negedge clk_sys);
		check("clear", {31'h0, warn_irq}, 32'h0);
		wait_out(1'b0, 100);
		wait_out(1'b1, 100);
		check("final", {31'h0, seen}, 32'h1);
		host.recover(rd);
		check("byte", rd, {24'h0, WARN_BYTE});
		host.xfer(1'b0, OFS_STATUS, ZERO_WORD, rd, err);
		check("drained", {rd[ST_VEND1], rd[ST_OBF]}, 2'b00);
	endtask
	initial begin
		#(25 * 20000);
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		t_regs();
		t_stop();
		t_direct();
		t_pre();
		end_of_test();
	end
endmodule
